/* File: design/wdtw_pkg.sv */
/*
 * Constants for the windowed watchdog, and the small modulo counter that it
 * uses for the oscillator divider and the prescaler.
 * Assumes one core clock of CORE_HZ.
 */
`timescale 1ns/1ps
package wdtw_pkg;
    localparam int unsigned CORE_HZ            = 20000000;
    localparam int unsigned LP_OSC_HZ          = 32000;
    // Core cycles per low-power oscillator period
    localparam int unsigned LP_OSC_DIV         = CORE_HZ / LP_OSC_HZ;
    localparam int unsigned OSC_W              = 10;
    // Nominal prescaler periods in microseconds
    localparam int unsigned PRE_PERIOD_5BIT_US = 1000;
    localparam int unsigned PRE_PERIOD_7BIT_US = 4000;
    localparam int unsigned PRE_DIV_5BIT       = PRE_PERIOD_5BIT_US * LP_OSC_HZ / 1000000;
    localparam int unsigned PRE_DIV_7BIT       = PRE_PERIOD_7BIT_US * LP_OSC_HZ / 1000000;
    localparam int unsigned PRE_W              = 7;
    localparam int unsigned POST_W             = 15;
    localparam int unsigned ELAPSED_W          = POST_W + PRE_W;
    // Configuration word layout
    localparam int unsigned CFG_W              = 8;
    localparam int unsigned CFG_POST_LSB       = 0;
    localparam int unsigned CFG_POST_W         = 4;
    localparam int unsigned CFG_PRESEL_BIT     = 4;
    localparam int unsigned CFG_WIN_OFF_BIT    = 6;
    localparam int unsigned CFG_HARDEN_BIT     = 7;
    localparam logic [CFG_W-1:0] CFG_RESET     = 8'hFF;
endpackage : wdtw_pkg

module wdtw_divider #(
    parameter int unsigned W = 7
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clr,
    input  wire logic         en,
    input  wire logic [W-1:0] last,
    output logic      [W-1:0] cnt,
    output logic              tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    assign tick    = en & (cnt_r == last);
    assign cnt_nxt = (clr | tick) ? '0 : (en ? cnt_r + W'(1) : cnt_r);
    assign cnt     = cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0; // see RULE_05
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : wdtw_divider

/* File: design/wdtw_top.sv */
/*
 * Windowed watchdog timer: oscillator divider, prescaler, postscaler,
 * window check, sleep wake-up and sticky time-out flag.
 * Assumes all inputs are synchronous to core_clk and that instruction,
 * clock-switch and exit inputs are one-cycle pulses.
 */
// Operation
// RULE_01: Counter runs from the low-power oscillator; enabling watchdog enables it.
// RULE_02: Prescaler divides by 32 or 128 per prescale select bit.
// RULE_03: Nominal prescaler period is 1 ms or 4 ms.
// RULE_04: Postscaler divides by one of 16 ratios, 1:1 to 1:32768.
// RULE_05: Any device reset clears counter, prescaler and postscaler.
// RULE_06: Completed clock switch clears counter, prescaler and postscaler.
// RULE_07: Entering sleep or idle clears counter, prescaler and postscaler.
// RULE_08: Leaving sleep or idle clears them again.
// RULE_09: Clear-watchdog instruction in normal running clears all counts.
// RULE_10: Enabled watchdog keeps counting in sleep and idle.
// RULE_11: Time-out in sleep or idle wakes device instead of resetting.
// RULE_12: Software clears sleep and idle status bits after a wake-up.
// RULE_13: Hard enable set keeps watchdog running whatever soft enable says.
// RULE_14: Time-out flag set by time-out, stays until software clears it.
// RULE_15: With hard enable clear, watchdog runs only while soft enable set.
// RULE_16: Any device reset clears the soft enable bit.
// RULE_17: Window mode: clear before last quarter causes watchdog reset.
// RULE_18: Software clears only within last quarter of the period in window mode.
// RULE_19: Window disable 1 means non-window, 0 means window operation.
// RULE_20: Time-out while running normally resets device and sets flag.
// RULE_21: Postscale setting N divides by two to the power N.
`timescale 1ns/1ps
module wdtw_top
    import wdtw_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             por_rst,
    input  wire logic [CFG_W-1:0] watchdog_config_word,
    input  wire logic             soft_enable_wr,
    input  wire logic             soft_enable_wdata,
    input  wire logic             timeout_flag_clr,
    input  wire logic             clear_watchdog_instr,
    input  wire logic             power_save_instr,
    input  wire logic             sleep_exit,
    input  wire logic             clock_switch_done,
    output logic                  low_power_rc_osc_en,
    output logic                  soft_enable,
    output logic                  timeout_flag,
    output logic                  asleep,
    output logic                  wdt_reset_req,
    output logic                  wake_req
);
    logic [CFG_W-1:0]      cfg_r;
    logic                  soft_en_r;
    logic                  flag_r;
    logic                  asleep_r;
    logic                  reset_req_r;
    logic                  wake_r;
    logic [POST_W-1:0]     post_r;
    logic [POST_W-1:0]     post_nxt;

    // Config is latched after reset release so strap-like inputs are not
    // loaded under the asynchronous reset.
    logic                  cfg_ld_r;

    wire                   cfg_hard   = cfg_r[CFG_HARDEN_BIT];
    wire                   cfg_win_off = cfg_r[CFG_WIN_OFF_BIT];
    wire                   cfg_presel = cfg_r[CFG_PRESEL_BIT];
    wire [CFG_POST_W-1:0]  cfg_post   = cfg_r[CFG_POST_LSB +: CFG_POST_W];

    wire                   running = cfg_hard | soft_en_r; // see RULE_13 see RULE_15

    logic [OSC_W-1:0]      osc_cnt;
    logic                  osc_tick;
    logic [PRE_W-1:0]      pre_cnt;
    logic                  pre_tick;

    wire [PRE_W-1:0] pre_last = cfg_presel ? PRE_W'(PRE_DIV_7BIT - 1)
                                           : PRE_W'(PRE_DIV_5BIT - 1); // see RULE_02 see RULE_03
    // Setting N ends the period after 2**N prescaler periods
    wire [POST_W-1:0] post_last = {POST_W{1'b1}} >> (4'hF - cfg_post); // see RULE_04 see RULE_21

    wire timeout     = pre_tick & (post_r == post_last);
    wire in_normal   = ~asleep_r;
    wire exit_event  = asleep_r & (sleep_exit | timeout);

    // Elapsed oscillator periods and the start of the last quarter
    wire [ELAPSED_W-1:0] elapsed = cfg_presel ? {post_r, pre_cnt}
                                              : {2'b00, post_r, pre_cnt[4:0]};
    wire [ELAPSED_W:0]   period  = (cfg_presel ? (ELAPSED_W+1)'(PRE_DIV_7BIT)
                                               : (ELAPSED_W+1)'(PRE_DIV_5BIT)) << cfg_post;
    wire [ELAPSED_W:0]   thresh  = period - (period >> 2);
    wire                 in_window = {1'b0, elapsed} >= thresh;

    wire clear_ok    = clear_watchdog_instr & in_normal;
    wire early_clr   = clear_ok & running & ~cfg_win_off & ~in_window; // see RULE_17 see RULE_19
    wire run_timeout = timeout & in_normal;
    wire slp_timeout = timeout & asleep_r;

    wire cnt_clr = ~running | clock_switch_done      // see RULE_06
                 | power_save_instr                  // see RULE_07
                 | exit_event                        // see RULE_08
                 | clear_ok                          // see RULE_09
                 | timeout;

    assign post_nxt = cnt_clr ? '0 : (pre_tick ? post_r + POST_W'(1) : post_r);

    // Oscillator is only powered while the watchdog runs
    wdtw_divider #(.W(OSC_W)) u_osc (
        .clk  (core_clk),
        .rst  (rst),
        .clr  (~running),
        .en   (running),
        .last (OSC_W'(LP_OSC_DIV - 1)),
        .cnt  (osc_cnt),
        .tick (osc_tick)
    ); // see RULE_01

    // Keeps counting in sleep: only the clear terms stop it
    wdtw_divider #(.W(PRE_W)) u_pre (
        .clk  (core_clk),
        .rst  (rst),
        .clr  (cnt_clr),
        .en   (osc_tick & running),
        .last (pre_last),
        .cnt  (pre_cnt),
        .tick (pre_tick)
    ); // see RULE_10

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            post_r <= '0; // see RULE_05
        end else begin
            post_r <= post_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_r    <= CFG_RESET;
            cfg_ld_r <= 1'b0;
        end else begin
            cfg_ld_r <= 1'b1;
            if (!cfg_ld_r) begin
                cfg_r <= watchdog_config_word;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            soft_en_r <= 1'b0; // see RULE_16
        end else if (soft_enable_wr) begin
            soft_en_r <= soft_enable_wdata;
        end
    end

    // Sleep and idle status bits belong to software; only the wake is ours
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            asleep_r <= 1'b0;
        end else if (power_save_instr) begin
            asleep_r <= 1'b1;
        end else if (exit_event) begin
            asleep_r <= 1'b0; // see RULE_11
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reset_req_r <= 1'b0;
            wake_r      <= 1'b0;
        end else begin
            reset_req_r <= run_timeout | early_clr; // see RULE_20 see RULE_17
            wake_r      <= slp_timeout;             // see RULE_11
        end
    end

    // Flag survives the watchdog reset it causes, so of the resets only power-on clears it.
    // Set wins over a clear in the same cycle.
    always_ff @(posedge core_clk or posedge por_rst) begin
        if (por_rst) begin
            flag_r <= 1'b0;
        end else if (timeout | early_clr) begin
            flag_r <= 1'b1; // see RULE_14 see RULE_20
        end else if (timeout_flag_clr) begin
            flag_r <= 1'b0;
        end
    end

    assign low_power_rc_osc_en = running; // see RULE_01
    assign soft_enable         = soft_en_r;
    assign timeout_flag        = flag_r;
    assign asleep              = asleep_r;
    assign wdt_reset_req       = reset_req_r;
    assign wake_req            = wake_r;

    wire cnts_zero = (post_r == '0) && (pre_cnt == '0);

    a_reset_timeout: assert property (@(posedge core_clk) disable iff (rst) // see RULE_20
        run_timeout |=> wdt_reset_req && !wake_req)
        else $error("running time-out did not request a reset");

    a_wake_sleep: assert property (@(posedge core_clk) disable iff (rst) // see RULE_11
        slp_timeout |=> wake_req && !wdt_reset_req && !asleep)
        else $error("sleep time-out did not wake the device");

    a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst || por_rst) // see RULE_14
        timeout_flag && !timeout_flag_clr |=> timeout_flag)
        else $error("time-out flag dropped without a clear");

    a_flag_set: assert property (@(posedge core_clk) disable iff (rst || por_rst) // see RULE_14
        timeout |=> timeout_flag)
        else $error("time-out did not set the flag");

    a_hard_run: assert property (@(posedge core_clk) disable iff (rst) // see RULE_13
        cfg_hard && soft_enable_wr && !soft_enable_wdata |=> low_power_rc_osc_en)
        else $error("hard enable lost to soft enable");

    a_soft_off: assert property (@(posedge core_clk) disable iff (rst) // see RULE_15
        !cfg_hard && !soft_en_r |=> cnts_zero && !wdt_reset_req)
        else $error("watchdog counted while disabled");

    a_clear_instr: assert property (@(posedge core_clk) disable iff (rst) // see RULE_09
        clear_ok |=> cnts_zero)
        else $error("clear instruction did not clear the counts");

    a_psave_clear: assert property (@(posedge core_clk) disable iff (rst) // see RULE_07
        power_save_instr |=> cnts_zero && asleep)
        else $error("power save did not clear the counts");

    a_exit_clear: assert property (@(posedge core_clk) disable iff (rst) // see RULE_08
        asleep_r && sleep_exit && !power_save_instr |=> cnts_zero && !asleep)
        else $error("sleep exit did not clear the counts");

    a_switch_clear: assert property (@(posedge core_clk) disable iff (rst) // see RULE_06
        clock_switch_done |=> cnts_zero)
        else $error("clock switch did not clear the counts");

    a_early_reset: assert property (@(posedge core_clk) disable iff (rst) // see RULE_17
        clear_ok && running && !cfg_win_off && !in_window |=> wdt_reset_req)
        else $error("early clear in window mode did not reset");

    a_nowin_free: assert property (@(posedge core_clk) disable iff (rst) // see RULE_19
        clear_ok && cfg_win_off && !timeout |=> !wdt_reset_req)
        else $error("clear caused reset with window disabled");

    a_pre_ratio: assert property (@(posedge core_clk) disable iff (rst) // see RULE_02
        pre_tick |-> pre_cnt == (cfg_presel ? 7'h7F : 7'h1F))
        else $error("prescaler ended at the wrong count");

    a_osc_space: assert property (@(posedge core_clk) disable iff (rst) // see RULE_01
        osc_tick |=> !osc_tick [*8])
        else $error("oscillator ticks too close together");

    a_sleep_count: assert property (@(posedge core_clk) disable iff (rst) // see RULE_10
        asleep_r && running && osc_tick && !pre_tick && !cnt_clr
        |=> pre_cnt == $past(pre_cnt) + 7'h01)
        else $error("prescaler stalled in sleep");

    // Postscaler steps once per prescaler period and never passes its end count
    a_post_step: assert property (@(posedge core_clk) disable iff (rst) // see RULE_04
        pre_tick && !cnt_clr |=> post_r == $past(post_r) + 15'h0001)
        else $error("postscaler missed a prescaler period");

    a_post_hold: assert property (@(posedge core_clk) disable iff (rst) // see RULE_04
        !pre_tick && !cnt_clr |=> post_r == $past(post_r))
        else $error("postscaler moved without a prescaler period");

    a_post_bound: assert property (@(posedge core_clk) disable iff (rst) // see RULE_21
        post_r <= post_last)
        else $error("postscaler passed its selected ratio");

    a_window_pass: assert property (@(posedge core_clk) disable iff (rst) // see RULE_17
        clear_ok && !cfg_win_off && in_window && !timeout |=> !wdt_reset_req)
        else $error("clear inside the window caused a reset");

    a_sleep_ignore: assert property (@(posedge core_clk) disable iff (rst) // see RULE_11
        asleep_r && clear_watchdog_instr |=> !wdt_reset_req)
        else $error("clear while asleep caused a reset");

    a_wake_single: assert property (@(posedge core_clk) disable iff (rst) // see RULE_11
        wake_req |=> !wake_req)
        else $error("wake request held longer than one cycle");

    a_awake_nowake: assert property (@(posedge core_clk) disable iff (rst) // see RULE_20
        !asleep_r |=> !wake_req)
        else $error("wake request while running normally");

    c_run_timeout: cover property (@(posedge core_clk) disable iff (rst) run_timeout);
    c_sleep_wake: cover property (@(posedge core_clk) disable iff (rst) slp_timeout);
    c_early_clear: cover property (@(posedge core_clk) disable iff (rst) early_clr);
    c_window_ok: cover property (@(posedge core_clk) disable iff (rst)
        clear_ok && !cfg_win_off && in_window);
    c_long_pre: cover property (@(posedge core_clk) disable iff (rst)
        osc_tick && cfg_presel && running);
endmodule : wdtw_top

/* File: bench/test_watchdog_timer_window.sv */
/*
 * Self-checking bench for the windowed watchdog: enable control, time-out,
 * sleep wake-up, window check and the clear sources.
 * Assumes the design package constants and a 20 MHz core clock.
 */
`timescale 1ns/1ps
module test_watchdog_timer_window;
    import wdtw_pkg::*;
    // Shortest period: prescale /32, postscale 1:1
    localparam int PER = LP_OSC_DIV * PRE_DIV_5BIT;
    // The oscillator phase is free, so allow one oscillator period early
    localparam int LO  = PER - LP_OSC_DIV - 4;
    localparam int HI  = PER + 4;

    logic       core_clk;
    logic       rst;
    logic       por_rst;
    logic [7:0] watchdog_config_word;
    logic       soft_enable_wr;
    logic       soft_enable_wdata;
    logic       timeout_flag_clr;
    logic       clear_watchdog_instr;
    logic       power_save_instr;
    logic       sleep_exit;
    logic       clock_switch_done;
    logic       low_power_rc_osc_en;
    logic       soft_enable;
    logic       timeout_flag;
    logic       asleep;
    logic       wdt_reset_req;
    logic       wake_req;
    int         fails;
    int         samples_checked;

    wdtw_top DUT (
        .core_clk             (core_clk),
        .rst                  (rst),
        .por_rst              (por_rst),
        .watchdog_config_word (watchdog_config_word),
        .soft_enable_wr       (soft_enable_wr),
        .soft_enable_wdata    (soft_enable_wdata),
        .timeout_flag_clr     (timeout_flag_clr),
        .clear_watchdog_instr (clear_watchdog_instr),
        .power_save_instr     (power_save_instr),
        .sleep_exit           (sleep_exit),
        .clock_switch_done    (clock_switch_done),
        .low_power_rc_osc_en  (low_power_rc_osc_en),
        .soft_enable          (soft_enable),
        .timeout_flag         (timeout_flag),
        .asleep               (asleep),
        .wdt_reset_req        (wdt_reset_req),
        .wake_req             (wake_req)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic check_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s is %b", $time, what, got);
        end
    endtask : check_bit

    task automatic check_cnt(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            fails++;
            $display("mismatch at %0t: %s is %0d", $time, what, got);
        end
    endtask : check_cnt

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    // 0 clear, 1 power save, 2 clock switch, 3 flag clear, 4 sleep exit
    task automatic pulse(input int k);
        case (k)
            0: clear_watchdog_instr = 1'b1;
            1: power_save_instr = 1'b1;
            2: clock_switch_done = 1'b1;
            3: timeout_flag_clr = 1'b1;
            default: sleep_exit = 1'b1;
        endcase
        tick(1);
        {clear_watchdog_instr, power_save_instr, clock_switch_done} = 3'h0;
        {timeout_flag_clr, sleep_exit} = 2'h0;
    endtask : pulse

    task automatic set_soft(input logic v);
        soft_enable_wdata = v;
        soft_enable_wr = 1'b1;
        tick(1);
        soft_enable_wr = 1'b0;
    endtask : set_soft

    task automatic do_reset(input logic [7:0] cfg, input logic por);
        rst = 1'b1;
        por_rst = por;
        watchdog_config_word = cfg;
        tick(8);
        rst = 1'b0;
        por_rst = 1'b0;
        tick(2);
    endtask : do_reset

    // Waits for the next request pulse and checks its kind, timing and width
    task automatic expect_evt(input logic wake, input int lo, input int hi);
        int n;
        n = 0;
        while (wdt_reset_req !== 1'b1 && wake_req !== 1'b1 && n < hi + 10) begin
            tick(1);
            n++;
        end
        check_cnt(n, lo, hi, "cycles to request");
        check_bit(wake_req, wake, "wake request");
        check_bit(wdt_reset_req, ~wake, "reset request");
        check_bit(timeout_flag, 1'b1, "flag after request");
        tick(1);
        check_bit(wdt_reset_req | wake_req, 1'b0, "request width");
    endtask : expect_evt

    initial begin
        fails = 0;
        samples_checked = 0;
        {soft_enable_wr, soft_enable_wdata, timeout_flag_clr} = 3'h0;
        {clear_watchdog_instr, power_save_instr, sleep_exit, clock_switch_done} = 4'h0;
        // Hard enable off, window off, /32, 1:1
        do_reset(8'h40, 1'b1);
        check_bit(soft_enable, 1'b0, "soft enable");
        check_bit(low_power_rc_osc_en, 1'b0, "osc enable");
        tick(400);
        check_bit(wdt_reset_req | timeout_flag, 1'b0, "idle watchdog");
        set_soft(1'b1);
        check_bit(low_power_rc_osc_en, 1'b1, "osc enable");
        tick(400);
        pulse(0);
        tick(400);
        pulse(2);
        expect_evt(1'b0, LO, HI);
        tick(5);
        check_bit(timeout_flag, 1'b1, "sticky flag");
        pulse(3);
        check_bit(timeout_flag, 1'b0, "cleared flag");
        $display("test enable_timeout done");

        tick(500);
        pulse(1);
        check_bit(asleep, 1'b1, "asleep");
        tick(3);
        pulse(4);
        check_bit(asleep, 1'b0, "asleep after exit");
        pulse(1);
        expect_evt(1'b1, LO, HI);
        check_bit(asleep, 1'b0, "asleep after wake");
        pulse(3);
        $display("test sleep_wake done");

        // Hard enable on, window mode, /128, 1:1: a clear that would sit in
        // the /32 window is still early here
        do_reset(8'h90, 1'b0);
        check_bit(soft_enable, 1'b0, "soft enable");
        check_bit(low_power_rc_osc_en, 1'b1, "osc enable");
        set_soft(1'b0);
        check_bit(low_power_rc_osc_en, 1'b1, "osc enable");
        tick(PER * 13 / 16);
        pulse(0);
        expect_evt(1'b0, 0, 2);
        $display("test early_clear done");

        do_reset(8'h80, 1'b1);
        tick(PER * 13 / 16);
        pulse(0);
        expect_evt(1'b0, LO, HI);
        $display("test window_clear done");
        give_verdict();
    end

    // Tests take about 94000 cycles
    initial begin
        repeat (100000) @(posedge core_clk);
        fails++;
        $display("mismatch at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule : test_watchdog_timer_window
